// ==== rtl/adc_cfg_regs.v ====
// Serial-port configuration bank: test pattern, signature, channel and sync control registers
`timescale 1ns/1ps
`default_nettype none
`include "adc_cfg_defines.vh"

module adc_cfg_regs
(
  // Clock and reset
  input wire clock,
  input wire rst_b,
  // Serial control port pins
  input wire sclk,
  input wire csb,
  input wire sdio_in,
  output reg sdio_out,
  output reg sdio_oe,
  // Sync pin and signature source
  input wire sync_pin,
  input wire [7:0] signature_low_byte_in,
  // Pattern and channel controls
  output reg [15:0] user_pattern_two,
  output reg out_of_range_enable_a,
  output reg out_of_range_enable_b,
  output reg converter_select_a,
  output reg converter_select_b,
  // Clock divider sync
  output wire divider_align,
  output reg master_sync_enable,
  output reg divider_sync_enable,
  output reg next_sync_only,
  // Pin and oscillator controls
  output reg output_enable_low_pin_enable,
  output reg low_rate_detect_enable,
  output reg low_rate_internal_oscillator_run,
  output reg sdio_pulldown_disable
);

  // ****************************************
  // Declarations
  // ****************************************
  reg [`SYNC_STAGES-1:0] sclk_sync_reg;
  reg [`SYNC_STAGES-1:0] csb_sync_reg;
  reg [`SYNC_STAGES-1:0] sdio_sync_reg;
  reg [`SYNC_STAGES-1:0] sync_pin_reg;
  reg sclk_prev_reg;
  reg [15:0] instruction_reg;
  reg [4:0] instruction_count_reg;
  reg [2:0] data_bit_reg;
  reg [7:0] data_shift_reg;
  reg [12:0] address_reg;
  reg read_mode_reg;
  reg [1:0] channel_index_reg;
  wire sclk_level;
  wire csb_level;
  wire sdio_level;
  wire sclk_rise;
  wire sclk_fall;
  wire frame_active;
  wire data_phase;
  wire write_strobe;
  wire [7:0] write_byte;
  wire divider_enable_clear;
  reg [7:0] read_byte;

  // Reset images of the packed registers; only the stored bits are picked out below
  localparam [2:0] sync_reset_image = `RST_DIVIDER_SYNC_CONTROL;
  localparam [7:0] misc_reset_image = `RST_MISC_PIN_OSC_CONTROL;

  // ****************************************
  // Register read decode
  // ****************************************
  // Channel A wins the read when both channels are indexed
  function pick_channel;
    input [1:0] index;
    input value_a;
    input value_b;
    begin
      pick_channel = index[`INDEX_CHANNEL_A_BIT] ? value_a : value_b;
    end
  endfunction

  // Every register value is a direct operand here, so a read never sees a stale byte
  always @*
  begin
    case (address_reg)
      `ADDR_CHANNEL_INDEX:
        read_byte = {6'h00, channel_index_reg};
      `ADDR_USER_PATTERN_TWO_LOW:
        read_byte = user_pattern_two[7:0];
      `ADDR_USER_PATTERN_TWO_HIGH:
        read_byte = user_pattern_two[15:8];
      `ADDR_SIGNATURE_LOW_BYTE:
        read_byte = signature_low_byte_in;
      `ADDR_CHANNEL_FEATURES:
        read_byte = {7'h00, pick_channel(channel_index_reg, out_of_range_enable_a, out_of_range_enable_b)};
      `ADDR_OUTPUT_CONVERTER_SELECT:
        read_byte = {7'h00, pick_channel(channel_index_reg, converter_select_a, converter_select_b)};
      `ADDR_DIVIDER_SYNC_CONTROL:
        read_byte = {5'h00, next_sync_only, divider_sync_enable, master_sync_enable};
      `ADDR_MISC_PIN_OSC_CONTROL:
        read_byte = {output_enable_low_pin_enable, 3'h0, low_rate_detect_enable,
                     low_rate_internal_oscillator_run, 1'b0, sdio_pulldown_disable};
      default:
        read_byte = 8'h00;
    endcase
  end

  // ****************************************
  // Pin synchronisers
  // ****************************************
  // Serial pins are asynchronous to the core clock; two stages before any use
  always @(posedge clock or negedge rst_b)
  begin
    if (!rst_b)
    begin
      sclk_sync_reg <= 2'h0;
      csb_sync_reg <= 2'h3;
      sdio_sync_reg <= 2'h0;
      sync_pin_reg <= 2'h0;
      sclk_prev_reg <= 1'b0;
    end
    else
    begin
      sclk_sync_reg <= {sclk_sync_reg[0], sclk};
      csb_sync_reg <= {csb_sync_reg[0], csb};
      sdio_sync_reg <= {sdio_sync_reg[0], sdio_in};
      sync_pin_reg <= {sync_pin_reg[0], sync_pin};
      sclk_prev_reg <= sclk_sync_reg[1];
    end
  end

  assign sclk_level = sclk_sync_reg[1];
  assign csb_level = csb_sync_reg[1];
  assign sdio_level = sdio_sync_reg[1];
  assign sclk_rise = sclk_level & ~sclk_prev_reg;
  assign sclk_fall = ~sclk_level & sclk_prev_reg;
  assign frame_active = ~csb_level;
  assign data_phase = (instruction_count_reg == `INSTRUCTION_BITS);

  // ****************************************
  // Serial frame engine
  // ****************************************
  // Sixteen instruction bits, then bytes; the address steps down after each byte
  always @(posedge clock or negedge rst_b)
  begin
    if (!rst_b)
    begin
      instruction_reg <= 16'h0000;
      instruction_count_reg <= 5'h00;
      data_bit_reg <= 3'h0;
      data_shift_reg <= 8'h00;
      address_reg <= 13'h0000;
      read_mode_reg <= 1'b0;
    end
    else if (!frame_active)
    begin
      instruction_count_reg <= 5'h00;
      data_bit_reg <= 3'h0;
    end
    else if (sclk_rise)
    begin
      if (!data_phase)
      begin
        instruction_reg <= {instruction_reg[14:0], sdio_level};
        instruction_count_reg <= instruction_count_reg + 5'h01;
        if (instruction_count_reg == `INSTRUCTION_BITS - 5'h01)
        begin
          read_mode_reg <= instruction_reg[`INSTRUCTION_READ_BIT - 1];
          address_reg <= {instruction_reg[11:0], sdio_level};
        end
      end
      else
      begin
        data_shift_reg <= {data_shift_reg[6:0], sdio_level};
        data_bit_reg <= data_bit_reg + 3'h1;
        if (data_bit_reg == `BYTE_LAST_BIT)
          address_reg <= address_reg - 13'h0001;
      end
    end
  end

  // Write commits on the eighth data rise of a write frame
  assign write_strobe = frame_active & sclk_rise & data_phase & ~read_mode_reg & (data_bit_reg == `BYTE_LAST_BIT);
  assign write_byte = {data_shift_reg[6:0], sdio_level};

  // ****************************************
  // Read data driver
  // ****************************************
  // Data changes on falling edges so the host samples a settled bit on the rise
  always @(posedge clock or negedge rst_b)
  begin
    if (!rst_b)
    begin
      sdio_out <= 1'b0;
      sdio_oe <= 1'b0;
    end
    else
    begin
      sdio_oe <= frame_active & data_phase & read_mode_reg;
      if (frame_active & data_phase & read_mode_reg & sclk_fall)
        sdio_out <= read_byte[`BYTE_LAST_BIT - data_bit_reg];
      else if (!frame_active)
        sdio_out <= 1'b0;
    end
  end

  // ****************************************
  // Writable registers
  // ****************************************
  // Open bits are simply not stored, so they can never read back as one
  always @(posedge clock or negedge rst_b)
  begin
    if (!rst_b)
    begin
      channel_index_reg <= `RST_CHANNEL_INDEX;
      user_pattern_two <= {`RST_USER_PATTERN_TWO, `RST_USER_PATTERN_TWO};
      out_of_range_enable_a <= `RST_CHANNEL_FEATURES;
      out_of_range_enable_b <= `RST_CHANNEL_FEATURES;
      converter_select_a <= `RST_CONVERTER_SELECT_A;
      converter_select_b <= `RST_CONVERTER_SELECT_B;
      master_sync_enable <= sync_reset_image[`SYNC_MASTER_ENABLE_BIT];
      divider_sync_enable <= sync_reset_image[`SYNC_DIVIDER_ENABLE_BIT];
      next_sync_only <= sync_reset_image[`SYNC_NEXT_ONLY_BIT];
      output_enable_low_pin_enable <= misc_reset_image[`MISC_OUTPUT_ENABLE_PIN_BIT];
      low_rate_detect_enable <= misc_reset_image[`MISC_LOW_RATE_DETECT_BIT];
      low_rate_internal_oscillator_run <= misc_reset_image[`MISC_OSC_RUN_BIT];
      sdio_pulldown_disable <= misc_reset_image[`MISC_PULLDOWN_DISABLE_BIT];
    end
    else
    begin
      // One-shot sync clears the enable; a host write in the same cycle wins
      if (divider_enable_clear)
        divider_sync_enable <= 1'b0;
      if (write_strobe)
      begin
        case (address_reg)
          `ADDR_CHANNEL_INDEX:
            channel_index_reg <= write_byte[1:0];
          `ADDR_USER_PATTERN_TWO_LOW:
            user_pattern_two[7:0] <= write_byte;
          `ADDR_USER_PATTERN_TWO_HIGH:
            user_pattern_two[15:8] <= write_byte;
          `ADDR_CHANNEL_FEATURES:
          begin
            if (channel_index_reg[`INDEX_CHANNEL_A_BIT])
              out_of_range_enable_a <= write_byte[0];
            if (channel_index_reg[`INDEX_CHANNEL_B_BIT])
              out_of_range_enable_b <= write_byte[0];
          end
          `ADDR_OUTPUT_CONVERTER_SELECT:
          begin
            if (channel_index_reg[`INDEX_CHANNEL_A_BIT])
              converter_select_a <= write_byte[0];
            if (channel_index_reg[`INDEX_CHANNEL_B_BIT])
              converter_select_b <= write_byte[0];
          end
          `ADDR_DIVIDER_SYNC_CONTROL:
          begin
            master_sync_enable <= write_byte[`SYNC_MASTER_ENABLE_BIT];
            divider_sync_enable <= write_byte[`SYNC_DIVIDER_ENABLE_BIT];
            next_sync_only <= write_byte[`SYNC_NEXT_ONLY_BIT];
          end
          `ADDR_MISC_PIN_OSC_CONTROL:
          begin
            output_enable_low_pin_enable <= write_byte[`MISC_OUTPUT_ENABLE_PIN_BIT];
            low_rate_detect_enable <= write_byte[`MISC_LOW_RATE_DETECT_BIT];
            low_rate_internal_oscillator_run <= write_byte[`MISC_OSC_RUN_BIT];
            sdio_pulldown_disable <= write_byte[`MISC_PULLDOWN_DISABLE_BIT];
          end
          // Signature and unmapped offsets drop the write
          default:
            channel_index_reg <= channel_index_reg;
        endcase
      end
    end
  end

  // ****************************************
  // Divider sync gating
  // ****************************************
  divider_sync_gate sync_gate
  (
    .clock(clock),
    .rst_b(rst_b),
    .master_sync_enable(master_sync_enable),
    .divider_sync_enable(divider_sync_enable),
    .next_sync_only(next_sync_only),
    .sync_level(sync_pin_reg[1]),
    .divider_align(divider_align),
    .divider_enable_clear(divider_enable_clear)
  );

endmodule

`default_nettype wire

// ==== rtl/adc_cfg_defines.vh ====
// Offsets, field positions, reset values and timing counts of the configuration bank
`ifndef ADC_CFG_DEFINES_VH
`define ADC_CFG_DEFINES_VH

// ****************************************
// Register offsets (13-bit serial address)
// ****************************************
`define ADDR_CHANNEL_INDEX 13'h0005
`define ADDR_USER_PATTERN_TWO_LOW 13'h001B
`define ADDR_USER_PATTERN_TWO_HIGH 13'h001C
`define ADDR_SIGNATURE_LOW_BYTE 13'h0024
`define ADDR_CHANNEL_FEATURES 13'h002A
`define ADDR_OUTPUT_CONVERTER_SELECT 13'h002E
`define ADDR_DIVIDER_SYNC_CONTROL 13'h0100
`define ADDR_MISC_PIN_OSC_CONTROL 13'h0101

// ****************************************
// Reset values
// ****************************************
`define RST_CHANNEL_INDEX 2'h3
`define RST_USER_PATTERN_TWO 8'h00
`define RST_CHANNEL_FEATURES 1'h1
`define RST_CONVERTER_SELECT_A 1'h0
`define RST_CONVERTER_SELECT_B 1'h1
`define RST_DIVIDER_SYNC_CONTROL 3'h1
`define RST_MISC_PIN_OSC_CONTROL 8'h88

// ****************************************
// Field positions and writable masks
// ****************************************
`define SYNC_MASTER_ENABLE_BIT 0
`define SYNC_DIVIDER_ENABLE_BIT 1
`define SYNC_NEXT_ONLY_BIT 2
`define MISC_OUTPUT_ENABLE_PIN_BIT 7
`define MISC_LOW_RATE_DETECT_BIT 3
`define MISC_OSC_RUN_BIT 2
`define MISC_PULLDOWN_DISABLE_BIT 0
`define MISC_WRITABLE_MASK 8'h8D
`define INDEX_CHANNEL_A_BIT 0
`define INDEX_CHANNEL_B_BIT 1

// ****************************************
// Serial frame layout and timing
// ****************************************
`define INSTRUCTION_BITS 5'h10
`define INSTRUCTION_READ_BIT 15
`define BYTE_LAST_BIT 3'h7
`define SYNC_STAGES 2

`endif

// ==== rtl/divider_sync_gate.v ====
// Gate that turns external sync pulses into clock divider alignment requests
`timescale 1ns/1ps
`default_nettype none

module divider_sync_gate
(
  // Clock and reset
  input wire clock,
  input wire rst_b,
  // Control bits
  input wire master_sync_enable,
  input wire divider_sync_enable,
  input wire next_sync_only,
  // Synchronised sync pin level
  input wire sync_level,
  // Results
  output reg divider_align,
  output reg divider_enable_clear
);

  reg sync_level_prev_reg;
  wire sync_rise;

  assign sync_rise = sync_level & ~sync_level_prev_reg;

  // ****************************************
  // Pulse gating
  // ****************************************
  // Nothing passes unless master sync is on; one-shot mode also clears the enable
  always @(posedge clock or negedge rst_b)
  begin
    if (!rst_b)
    begin
      sync_level_prev_reg <= 1'b0;
      divider_align <= 1'b0;
      divider_enable_clear <= 1'b0;
    end
    else
    begin
      sync_level_prev_reg <= sync_level;
      divider_align <= sync_rise & master_sync_enable & divider_sync_enable;
      divider_enable_clear <= sync_rise & master_sync_enable & divider_sync_enable & next_sync_only;
    end
  end

endmodule

`default_nettype wire

// ==== tb/adc_cfg_regs_props.sv ====
// Port-level checks on the configuration bank
`timescale 1ns/1ps
`default_nettype none
module adc_cfg_regs_props
(
  // Clock and reset
  input wire logic clock,
  input wire logic rst_b,
  // Serial pins
  input wire logic sclk,
  input wire logic csb,
  input wire logic sdio_in,
  input wire logic sdio_out,
  input wire logic sdio_oe,
  // Sync and signature
  input wire logic sync_pin,
  input wire logic [7:0] signature_low_byte_in,
  // Register outputs
  input wire logic [15:0] user_pattern_two,
  input wire logic out_of_range_enable_a,
  input wire logic out_of_range_enable_b,
  input wire logic converter_select_a,
  input wire logic converter_select_b,
  input wire logic divider_align,
  input wire logic master_sync_enable,
  input wire logic divider_sync_enable,
  input wire logic next_sync_only,
  input wire logic output_enable_low_pin_enable,
  input wire logic low_rate_detect_enable,
  input wire logic low_rate_internal_oscillator_run,
  input wire logic sdio_pulldown_disable
);
  // ****************************************
  // Assertions
  // ****************************************
  default clocking @(posedge clock); endclocking
  default disable iff (!rst_b);
  // Reset values on the first edge after release
  sync_rst_val_a: assert property ($rose(rst_b) |->
    {next_sync_only, divider_sync_enable, master_sync_enable} == 3'h1) else $error("sync reset value wrong");
  misc_rst_val_a: assert property ($rose(rst_b) |-> user_pattern_two == 16'h0000 &&
    {output_enable_low_pin_enable, low_rate_detect_enable, low_rate_internal_oscillator_run, sdio_pulldown_disable}
    == 4'hC) else $error("misc reset value wrong");
  chan_rst_val_a: assert property ($rose(rst_b) |->
    {out_of_range_enable_a, out_of_range_enable_b, converter_select_a, converter_select_b} == 4'hD)
    else $error("channel reset value wrong");
  // Sync gating, one-shot and continuous modes
  master_gate_a: assert property (divider_align |->
    $past(master_sync_enable) && $past(divider_sync_enable)) else $error("align without enables");
  once_clear_a: assert property (divider_align && next_sync_only |=>
    !divider_sync_enable) else $error("sync enable not cleared");
  continuous_keep_a: assert property (divider_align && !next_sync_only |=>
    divider_sync_enable && !divider_align) else $error("continuous sync lost or long pulse");
  align_cause_a: assert property (divider_align |->
    $past(sync_pin, 2) || $past(sync_pin, 3) || $past(sync_pin, 4)) else $error("align without sync pulse");
  // Pattern, converter select B and pin enable hold while the port is idle; data pin released after frame
  idle_stable_a: assert property (csb && $past(csb, 8) |->
    $stable(user_pattern_two) && $stable(converter_select_b) && $stable(output_enable_low_pin_enable))
    else $error("register moved while idle");
  oe_idle_a: assert property (csb [*6] |-> !sdio_oe) else $error("data pin driven outside frame");
endmodule
bind adc_cfg_regs adc_cfg_regs_props u_props (.*);
`default_nettype wire

// ==== tb/spi_host_model.sv ====
// Host controller model for the serial control port
`timescale 1ns/1ps
`default_nettype none
module spi_host_model
(
  // Clock
  input wire logic clock,
  // Serial pins
  output logic sclk,
  output logic csb,
  output wire logic sdio_in,
  input wire logic sdio_out,
  input wire logic sdio_oe
);
  logic host_bit;
  // Shared data wire: device wins while it drives
  assign sdio_in = sdio_oe ? sdio_out : host_bit;
  // Idle pins; serial clock stands still between frames
  initial
  begin
    sclk = 1'b0;
    csb = 1'b1;
    host_bit = 1'b0;
  end
  // Each pin level held five core cycles, above the four needed
  task automatic half;
    repeat (5) @(negedge clock);
  endtask
  // One frame: instruction MSB first, then one byte
  task automatic xfer(input logic rd, input logic [12:0] a, input logic [7:0] wd, output logic [7:0] q);
    logic [23:0] bits;
    bits = {rd, 2'b00, a, wd};
    csb = 1'b0;
    half;
    for (int i = 23; i >= 0; i--)
    begin
      host_bit = bits[i];
      half;
      sclk = 1'b1;
      if (i < 8)
        q[i] = sdio_in;
      half;
      sclk = 1'b0;
    end
    half;
    csb = 1'b1;
    host_bit = ~host_bit; // Released line shows no stale value
    half;
  endtask
endmodule
`default_nettype wire

// ==== tb/testbench.sv ====
// Self-checking bench for the configuration bank
`timescale 1ns/1ps
`default_nettype none
module testbench;
  logic clock = 1'b0, rst_b = 1'b0, sync_pin = 1'b0;
  logic sclk, csb, sdio_out, sdio_oe, divider_align;
  wire sdio_in;
  logic [7:0] signature_low_byte_in = 8'h3C;
  logic [15:0] user_pattern_two;
  logic out_of_range_enable_a, out_of_range_enable_b, converter_select_a, converter_select_b;
  logic master_sync_enable, divider_sync_enable, next_sync_only;
  logic output_enable_low_pin_enable, low_rate_detect_enable, low_rate_internal_oscillator_run;
  logic sdio_pulldown_disable;
  logic [7:0] rdata;
  int num_errors = 0, total_checks = 0, n_align = 0;
  // Rows: address, byte written, byte read back
  logic [28:0] rows [8] = '{{13'h001B, 8'hA5, 8'hA5}, {13'h001C, 8'h5A, 8'h5A}, {13'h002A, 8'hFE, 8'h00},
    {13'h002E, 8'hFF, 8'h01}, {13'h0101, 8'hFF, 8'h8D}, {13'h0100, 8'hF8, 8'h00},
    {13'h0024, 8'h00, 8'h3C}, {13'h0077, 8'hFF, 8'h00}};
  adc_cfg_regs u_dut (.*);
  spi_host_model u_host (.*);
  // ****************************************
  // Clock, helpers and watchdog
  // ****************************************
  always #2.5 clock = ~clock;
  always @(posedge clock) if (divider_align === 1'b1) n_align++;
  task automatic check(input string name, input logic [15:0] exp, input logic [15:0] got);
    total_checks++;
    if (got !== exp)
    begin
      num_errors++;
      $display("Error %s expected %h got %h", name, exp, got);
    end
  endtask
  task automatic wr(input logic [12:0] a, input logic [7:0] d);
    u_host.xfer(1'b0, a, d, rdata);
  endtask
  task automatic rd(input logic [12:0] a, input logic [7:0] exp);
    u_host.xfer(1'b1, a, 8'h00, rdata);
    check("read", {8'h00, exp}, {8'h00, rdata});
  endtask
  // Sync pulse held four cycles; count aligns that follow
  task automatic pulse(input int exp);
    n_align = 0;
    sync_pin = 1'b1;
    repeat (4) @(negedge clock);
    sync_pin = 1'b0;
    repeat (8) @(negedge clock);
    check("align count", exp[15:0], n_align[15:0]);
  endtask
  task automatic end_sim;
    $display("Checks %0d errors %0d", total_checks, num_errors);
    if (num_errors == 0 && total_checks > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask
  // Frames take about 260 cycles; far fewer than this limit
  initial
  begin
    repeat (30000) @(posedge clock);
    num_errors++;
    end_sim;
  end
  // ****************************************
  // Test sequence
  // ****************************************
  initial
  begin
    repeat (20) @(negedge clock);
    rst_b = 1'b1;
    repeat (4) @(negedge clock);
    foreach (rows[i])
    begin
      wr(rows[i][28:16], rows[i][15:8]);
      rd(rows[i][28:16], rows[i][7:0]);
    end
    check("pattern", 16'h5AA5, user_pattern_two);
    check("channel", 16'h0003, {12'h000, out_of_range_enable_a, out_of_range_enable_b,
      converter_select_a, converter_select_b});
    check("misc", 16'h000F, {12'h000, output_enable_low_pin_enable, low_rate_detect_enable,
      low_rate_internal_oscillator_run, sdio_pulldown_disable});
    $display("Test register rows done");
    // Second reset in mid-run restores every field
    rst_b = 1'b0;
    repeat (3) @(negedge clock);
    check("reset", 16'h0DC3, {user_pattern_two[3:0], out_of_range_enable_a, out_of_range_enable_b,
      converter_select_a, converter_select_b, output_enable_low_pin_enable, low_rate_detect_enable,
      low_rate_internal_oscillator_run, sdio_pulldown_disable, next_sync_only, divider_sync_enable,
      master_sync_enable, 1'b1});
    rst_b = 1'b1;
    repeat (4) @(negedge clock);
    rd(13'h0101, 8'h88);
    rd(13'h001C, 8'h00);
    // Index channel B only: a features write must leave channel A alone
    wr(13'h0005, 8'h02);
    wr(13'h002A, 8'h00);
    check("indexed", 16'h0002, {14'h0000, out_of_range_enable_a, out_of_range_enable_b});
    rd(13'h002A, 8'h00);
    $display("Test reset done");
    // Master off: no divider sync at all
    wr(13'h0100, 8'h02);
    pulse(0);
    // Continuous mode realigns every pulse
    wr(13'h0100, 8'h03);
    pulse(1);
    pulse(1);
    // Next-only mode aligns once then clears its enable
    wr(13'h0100, 8'h07);
    pulse(1);
    check("sync enable", 16'h0000, {15'h0000, divider_sync_enable});
    pulse(0);
    rd(13'h0100, 8'h05);
    $display("Test sync done");
    end_sim;
  end
endmodule
`default_nettype wire
